//--- hw/core_load_defines.vh
// constants shared by the load/move decoder and its saved register bank
`ifndef CORE_LOAD_DEFINES_VH
`define CORE_LOAD_DEFINES_VH
`define GPR_RESET 16'h0000
`define EXT_RESET 6'h00
`define SAVED_RESET 16'h0000
`define SAVED_RESERVED_READ 16'h0000
`define PC_READ_OFFSET 22'h000004
`define ZF_REG6 4'h6
`define ZF_REG7 4'h7
`define BYTE_BASE_EXT_REG 3'h0
`define OPC_EXT_MOVE_HI 5'h15
`define OPC_EXT_MOVE_LO 5'h03
`define OPC_SHORT_IMM 4'h1
`define OPC_IMM16 12'h8DF
`define OPC_EXT_XFER_HI 5'h14
`define OPC_EXT_XFER_LO 4'h1
`define OPC_BYTE_LARGE_LO 4'h3
`define OPC_BYTE_SHORT 3'h3
`define OPC_BYTE_R0 7'h4E
`define OPC_CODE_READ 4'hA
`define OPC_PC_READ 13'h13DE
`define OPC_SAVED_RD 12'h9EA
`define OPC_SAVED_WR 12'h9EB
`define SEL_FAST_PC_LOW 4'h0
`define SEL_FAST_PC_HIGH 4'h1
`define SEL_FAST_STATUS 4'h2
`define SEL_NORM_PC_LOW 4'h4
`define SEL_NORM_PC_HIGH 4'h5
`define SEL_NORM_STATUS 4'h6
`define SEL_SOFT_STATUS 4'hA
`endif

//--- hw/saved_reg_bank.v
// interrupt saved registers reached by the saved register transfer
`timescale 1ns/1ps
`include "core_load_defines.vh"
module saved_reg_bank (
  input wire ref_clk, // core clock
  input wire arst_n, // asynchronous reset, active low
  input wire wrEn, // one-cycle write strobe
  input wire [3:0] savedRegSelector, // selects which saved register
  input wire [15:0] wrData, // value to store
  output reg [15:0] rdData // selected register, combinational
);
  reg [15:0] saved_r [0:6]; // fast pc low/high/status, normal pc low/high/status, soft status
  wire [3:0] idx; // decoded slot, 4'hF when reserved
  integer i;

  // map a selector code onto a storage slot
  function [3:0] slotOf;
    input [3:0] sel;
    begin
      case (sel)
        `SEL_FAST_PC_LOW: slotOf = 4'h0;
        `SEL_FAST_PC_HIGH: slotOf = 4'h1;
        `SEL_FAST_STATUS: slotOf = 4'h2;
        `SEL_NORM_PC_LOW: slotOf = 4'h3;
        `SEL_NORM_PC_HIGH: slotOf = 4'h4;
        `SEL_NORM_STATUS: slotOf = 4'h5;
        `SEL_SOFT_STATUS: slotOf = 4'h6;
        default: slotOf = 4'hF;
      endcase
    end
  endfunction

  assign idx = slotOf(savedRegSelector);

  // store; reserved codes write nothing
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      for (i = 0; i < 7; i = i + 1) begin
        saved_r[i] <= `SAVED_RESET;
      end
    end else if (wrEn && idx != 4'hF) begin
      saved_r[idx[2:0]] <= wrData;
    end
  end

  // read mux; reserved codes read as a fixed value
  always @* begin
    if (idx == 4'hF) begin
      rdData = `SAVED_RESERVED_READ;
    end else begin
      rdData = saved_r[idx[2:0]];
    end
  end
endmodule // saved_reg_bank

//--- hw/core_load_instruction_decode.v
// decode and execute of the core's load and move instruction group
// What this block does
// - extended move copies all 22 bits
// - short immediate sets low byte, clears high
// - short load to reg6/7 updates zero flag
// - 16-bit immediate taken from second word
// - 16-bit load to reg6/7 updates zero flag
// - large immediate: six bits plus second word
// - two-word instructions take two fetch cycles
// - extension transfer zero-extends or keeps six bits
// - short byte access: base plus 4-bit displacement
// - large byte access: base plus second word
// - indexed byte access: base plus index register
// - 8-bit displacement form uses reg0, ext0
// - code read loads word from program memory
// - pc read stores instruction address plus four
// - saved register read goes to reg0
// - saved register write takes reg0
// - selector codes name the seven saved registers
// - extended register is extension plus general part
`timescale 1ns/1ps
`include "core_load_defines.vh"
module core_load_instruction_decode (
  input wire ref_clk, // core clock, 40 MHz
  input wire arst_n, // asynchronous reset, active low
  input wire instrValid, // instruction word offered
  input wire [15:0] instrWord, // instruction or trailing word
  input wire [21:0] instrAddr, // address of the first word
  output wire instrReady, // word taken when valid and ready
  output wire dmReq, // data memory byte request, level
  output wire dmWe, // 1 store, 0 load
  output wire [21:0] dmAddr, // data memory byte address
  output wire [7:0] dmWdata, // store byte
  input wire [7:0] dmRdata, // load byte, valid with ack
  input wire dmAck, // data memory done
  output wire pmReq, // program memory read request, level
  output wire [21:0] pmAddr, // program memory address
  input wire [15:0] pmRdata, // program word, valid with ack
  input wire pmAck, // program memory done
  output wire zeroFlagReg6, // zero flag of register 6
  output wire zeroFlagReg7, // zero flag of register 7
  output wire otherOp, // pulse: word outside this group ignored
  input wire [3:0] dbgSel, // register observation select
  output wire [15:0] dbgGpr, // selected general register
  output wire [5:0] dbgExt // selected extension register
);
  localparam ST_IDLE = 2'b00; // waiting for a first word
  localparam ST_WORD2 = 2'b01; // waiting for the trailing word
  localparam ST_DMEM = 2'b10; // data memory access in flight
  localparam ST_PMEM = 2'b11; // program memory read in flight

  localparam OP_NONE = 4'h0; // not in this group
  localparam OP_EXTMOVE = 4'h1;
  localparam OP_SHORTIMM = 4'h2;
  localparam OP_IMM16 = 4'h3;
  localparam OP_LARGEIMM = 4'h4;
  localparam OP_EXTXFER = 4'h5;
  localparam OP_BYTESHORT = 4'h6;
  localparam OP_BYTELARGE = 4'h7;
  localparam OP_BYTEINDEX = 4'h8;
  localparam OP_BYTER0 = 4'h9;
  localparam OP_CODEREAD = 4'hA;
  localparam OP_PCREAD = 4'hB;
  localparam OP_SAVEDRD = 4'hC;
  localparam OP_SAVEDWR = 4'hD;

  reg [15:0] gpr [0:15]; // general registers; 8..15 are the low parts of extended regs
  reg [5:0] ext [0:7]; // extension parts of extended regs
  reg [1:0] state_r; // sequencer state
  reg [3:0] op_r; // op held across the second word or memory wait
  reg [15:0] word_r; // first word held for two-word ops
  wire [21:0] pcPlus4; // first-word address plus the read offset, wraps at 22 bits
  reg [3:0] dst_r; // destination register of a pending load
  reg dmReq_r; // data memory request
  reg dmWe_r; // data memory direction
  reg [21:0] dmAddr_r; // data memory address
  reg [7:0] dmWdata_r; // store byte
  reg pmReq_r; // program memory request
  reg [21:0] pmAddr_r; // program memory address
  reg zf6_r; // zero flag of register 6
  reg zf7_r; // zero flag of register 7
  reg otherOp_r; // pulse for ignored words
  reg [15:0] dbgGpr_r; // observation of a general register
  reg [5:0] dbgExt_r; // observation of an extension register
  wire [21:0] aVal [0:7]; // extended register values
  wire [3:0] opNow; // class of the word on instrWord
  wire [15:0] savedRd; // saved register read data
  wire savedWrEn; // saved register write strobe
  wire [15:0] curWord; // first word of the op being started
  reg [21:0] byteAddr; // byte address for the op being started
  reg [2:0] byteDreg; // data register of the byte op
  integer i;

  // each extended register is its extension part over a general register
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : extJoin
      assign aVal[g] = {ext[g], gpr[g + 8]};
    end
  endgenerate

  // classify a first word; overlapping patterns are disjoint by their fixed bits
  function [3:0] classify;
    input [15:0] w;
    begin
      if (w[15:11] == `OPC_EXT_MOVE_HI && w[7:3] == `OPC_EXT_MOVE_LO) begin
        classify = OP_EXTMOVE;
      end else if (w[15:11] == `OPC_EXT_MOVE_HI && w[7:6] == 2'b10) begin
        classify = OP_LARGEIMM;
      end else if (w[15:12] == `OPC_SHORT_IMM) begin
        classify = OP_SHORTIMM;
      end else if (w[15:4] == `OPC_IMM16) begin
        classify = OP_IMM16;
      end else if (w[15:11] == `OPC_EXT_XFER_HI && w[7:4] == `OPC_EXT_XFER_LO) begin
        classify = OP_EXTXFER;
      end else if (w[15:11] == `OPC_EXT_XFER_HI && w[7:4] == `OPC_BYTE_LARGE_LO) begin
        classify = OP_BYTELARGE;
      end else if (w[15:13] == `OPC_BYTE_SHORT && !w[11]) begin
        classify = w[7] ? OP_BYTEINDEX : OP_BYTESHORT;
      end else if (w[15:9] == `OPC_BYTE_R0) begin
        classify = OP_BYTER0;
      end else if (w[15:12] == `OPC_CODE_READ && w[7:3] == 5'h00) begin
        classify = OP_CODEREAD;
      end else if (w[15:3] == `OPC_PC_READ) begin
        classify = OP_PCREAD;
      end else if (w[15:4] == `OPC_SAVED_RD) begin
        classify = OP_SAVEDRD;
      end else if (w[15:4] == `OPC_SAVED_WR) begin
        classify = OP_SAVEDWR;
      end else begin
        classify = OP_NONE;
      end
    end
  endfunction

  assign opNow = classify(instrWord);
  assign instrReady = (state_r == ST_IDLE) || (state_r == ST_WORD2);
  assign curWord = (state_r == ST_IDLE) ? instrWord : word_r;
  // one 22-bit sum feeds both halves, so the carry into the extension part is kept
  assign pcPlus4 = instrAddr + `PC_READ_OFFSET;
  assign savedWrEn = (state_r == ST_IDLE) && instrValid && (opNow == OP_SAVEDWR);

  saved_reg_bank savedBank (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .wrEn(savedWrEn),
    .savedRegSelector(instrWord[3:0]),
    .wrData(gpr[0]),
    .rdData(savedRd)
  );

  // byte address and data register for whichever byte form starts now
  always @* begin
    byteDreg = curWord[10:8];
    byteAddr = aVal[curWord[6:4]] + {18'h00000, curWord[3:0]};
    case (state_r == ST_IDLE ? opNow : op_r)
      OP_BYTEINDEX: begin
        byteAddr = aVal[curWord[6:4]] + {6'h00, gpr[curWord[3:0]]};
      end
      OP_BYTER0: begin
        byteDreg = 3'h0;
        byteAddr = aVal[`BYTE_BASE_EXT_REG] + {14'h0000, curWord[7:0]};
      end
      OP_BYTELARGE: begin
        byteAddr = aVal[curWord[2:0]] + {6'h00, instrWord};
      end
      default: begin
        byteDreg = curWord[10:8];
      end
    endcase
  end

  // sequencer and register writes
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      for (i = 0; i < 16; i = i + 1) begin
        gpr[i] <= `GPR_RESET;
      end
      for (i = 0; i < 8; i = i + 1) begin
        ext[i] <= `EXT_RESET;
      end
      state_r <= ST_IDLE;
      op_r <= OP_NONE;
      word_r <= 16'h0000;
      dst_r <= 4'h0;
      dmReq_r <= 1'b0;
      dmWe_r <= 1'b0;
      dmAddr_r <= 22'h000000;
      dmWdata_r <= 8'h00;
      pmReq_r <= 1'b0;
      pmAddr_r <= 22'h000000;
      zf6_r <= 1'b0;
      zf7_r <= 1'b0;
      otherOp_r <= 1'b0;
    end else begin
      otherOp_r <= 1'b0;
      case (state_r)
        ST_IDLE: if (instrValid) begin
          op_r <= opNow;
          word_r <= instrWord;
          case (opNow)
            OP_EXTMOVE: begin
              ext[instrWord[10:8]] <= aVal[instrWord[2:0]][21:16];
              gpr[{1'b1, instrWord[10:8]}] <= aVal[instrWord[2:0]][15:0];
            end
            OP_SHORTIMM: begin
              gpr[instrWord[11:8]] <= {8'h00, instrWord[7:0]};
              if (instrWord[11:8] == `ZF_REG6) begin
                zf6_r <= (instrWord[7:0] == 8'h00);
              end
              if (instrWord[11:8] == `ZF_REG7) begin
                zf7_r <= (instrWord[7:0] == 8'h00);
              end
            end
            OP_IMM16, OP_LARGEIMM, OP_BYTELARGE: begin
              state_r <= ST_WORD2;
            end
            OP_EXTXFER: begin
              if (instrWord[3]) begin
                ext[instrWord[2:0]] <= gpr[instrWord[10:8]][5:0];
              end else begin
                gpr[instrWord[10:8]] <= {10'h000, ext[instrWord[2:0]]};
              end
            end
            OP_BYTESHORT, OP_BYTEINDEX, OP_BYTER0: begin
              // byte r0 form puts direction in bit 8, the others in bit 12
              dmWe_r <= (opNow == OP_BYTER0) ? instrWord[8] : instrWord[12];
              dmAddr_r <= byteAddr;
              dmWdata_r <= gpr[byteDreg][7:0];
              dst_r <= {1'b0, byteDreg};
              dmReq_r <= 1'b1;
              state_r <= ST_DMEM;
            end
            OP_CODEREAD: begin
              pmAddr_r <= aVal[instrWord[2:0]];
              dst_r <= instrWord[11:8];
              pmReq_r <= 1'b1;
              state_r <= ST_PMEM;
            end
            OP_PCREAD: begin
              ext[instrWord[2:0]] <= pcPlus4[21:16];
              gpr[{1'b1, instrWord[2:0]}] <= pcPlus4[15:0];
            end
            OP_SAVEDRD: begin
              gpr[0] <= savedRd;
            end
            OP_SAVEDWR: begin
              op_r <= OP_SAVEDWR; // bank write strobed combinationally this cycle
            end
            default: begin
              otherOp_r <= 1'b1; // word belongs to another group
            end
          endcase
        end
        ST_WORD2: if (instrValid) begin
          state_r <= ST_IDLE;
          case (op_r)
            OP_IMM16: begin
              gpr[word_r[3:0]] <= instrWord;
              if (word_r[3:0] == `ZF_REG6) begin
                zf6_r <= (instrWord == 16'h0000);
              end
              if (word_r[3:0] == `ZF_REG7) begin
                zf7_r <= (instrWord == 16'h0000);
              end
            end
            OP_LARGEIMM: begin
              ext[word_r[10:8]] <= word_r[5:0];
              gpr[{1'b1, word_r[10:8]}] <= instrWord;
            end
            default: begin
              dmWe_r <= word_r[3];
              dmAddr_r <= byteAddr;
              dmWdata_r <= gpr[byteDreg][7:0];
              dst_r <= {1'b0, byteDreg};
              dmReq_r <= 1'b1;
              state_r <= ST_DMEM;
            end
          endcase
        end
        ST_DMEM: if (dmAck) begin
          dmReq_r <= 1'b0;
          if (!dmWe_r) begin
            gpr[dst_r] <= {8'h00, dmRdata}; // loaded byte is zero-extended
          end
          state_r <= ST_IDLE;
        end
        default: if (pmAck) begin
          pmReq_r <= 1'b0;
          gpr[dst_r] <= pmRdata;
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // observation registers, one cycle behind the select
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      dbgGpr_r <= 16'h0000;
      dbgExt_r <= 6'h00;
    end else begin
      dbgGpr_r <= gpr[dbgSel];
      dbgExt_r <= ext[dbgSel[2:0]];
    end
  end

  assign dmReq = dmReq_r;
  assign dmWe = dmWe_r;
  assign dmAddr = dmAddr_r;
  assign dmWdata = dmWdata_r;
  assign pmReq = pmReq_r;
  assign pmAddr = pmAddr_r;
  assign zeroFlagReg6 = zf6_r;
  assign zeroFlagReg7 = zf7_r;
  assign otherOp = otherOp_r;
  assign dbgGpr = dbgGpr_r;
  assign dbgExt = dbgExt_r;
endmodule // core_load_instruction_decode

//--- verification/load_decode_checker.sv
// assertion checker for the load and move decoder ports
`timescale 1ns/1ps
module load_decode_checker (
  input wire ref_clk, // core clock
  input wire arst_n, // async reset, active low
  input wire instrValid, // word offered
  input wire [15:0] instrWord, // offered word
  input wire instrReady, // word accepted
  input wire dmReq, // data request
  input wire dmWe, // store select
  input wire [21:0] dmAddr, // byte address
  input wire dmAck, // data done
  input wire pmReq, // code request
  input wire [21:0] pmAddr, // code address
  input wire pmAck, // code done
  input wire zeroFlagReg6, // zero flag 6
  input wire zeroFlagReg7 // zero flag 7
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  wire take = instrValid && instrReady; // word taken at this edge
  wire twoWord = (instrWord[15:4] == 12'h8DF) || (instrWord[15:11] == 5'h15 && instrWord[7:6] == 2'b10)
    || (instrWord[15:11] == 5'h14 && instrWord[7:4] == 4'h3); // opcodes with a trailing word
  reg trailPend_r; // next taken word is a trailing word
  reg [15:0] head_r; // last taken word
  wire first = take && !trailPend_r; // an opcode word is taken
  // follow word pairing so trailing words are never decoded as opcodes
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      trailPend_r <= 1'b0;
      head_r <= 16'h0000;
    end else if (take) begin
      trailPend_r <= !trailPend_r && twoWord;
      head_r <= instrWord;
    end
  end
  a_trail_ready: assert property (trailPend_r |-> instrReady)
    else $error("trailing word refused");
  a_large_first: assert property (
    first && instrWord[15:11] == 5'h14 && instrWord[7:4] == 4'h3 |=> !dmReq && instrReady)
    else $error("access before trailing word");
  a_large_access: assert property (take && trailPend_r && head_r[15:11] == 5'h14 |=> dmReq)
    else $error("no access after trailing word");
  a_busy_refuse: assert property (dmReq || pmReq |-> !instrReady)
    else $error("word taken while busy");
  a_dm_hold: assert property (dmReq && !dmAck |=> dmReq && $stable(dmAddr) && $stable(dmWe))
    else $error("data request changed early");
  a_dm_drop: assert property (dmReq && dmAck |=> !dmReq)
    else $error("data request kept after answer");
  a_pm_hold: assert property (pmReq && !pmAck |=> pmReq && $stable(pmAddr))
    else $error("code request changed early");
  a_short_zero: assert property (
    first && instrWord[15:8] == 8'h16 |=> zeroFlagReg6 == ($past(instrWord[7:0]) == 8'h00))
    else $error("short load flag wrong");
  a_imm_zero: assert property (
    take && trailPend_r && head_r == 16'h8DF7 |=> zeroFlagReg7 == ($past(instrWord) == 16'h0000))
    else $error("word load flag wrong");
  a_byte_dir: assert property (
    first && instrWord[15:13] == 3'b011 && !instrWord[11] |=> dmReq && dmWe == $past(instrWord[12]))
    else $error("byte direction wrong");
  a_r0_dir: assert property (
    first && instrWord[15:9] == 7'h4E |=> dmReq && dmWe == $past(instrWord[8]))
    else $error("register 0 byte direction wrong");
  a_code_req: assert property (
    first && instrWord[15:12] == 4'hA && instrWord[7:3] == 5'h00 |=> pmReq && !dmReq)
    else $error("code read not issued");
endmodule // load_decode_checker
bind core_load_instruction_decode load_decode_checker u_chk (.ref_clk(ref_clk), .arst_n(arst_n),
  .instrValid(instrValid), .instrWord(instrWord), .instrReady(instrReady), .dmReq(dmReq), .dmWe(dmWe),
  .dmAddr(dmAddr), .dmAck(dmAck), .pmReq(pmReq), .pmAddr(pmAddr), .pmAck(pmAck),
  .zeroFlagReg6(zeroFlagReg6), .zeroFlagReg7(zeroFlagReg7));

//--- verification/mem_partner.sv
// program and data memory model answering the decoder
`timescale 1ns/1ps
module mem_partner (
  input wire ref_clk, // core clock
  input wire [3:0] lag, // idle cycles before each answer
  input wire dmReq, // data request
  input wire dmWe, // store select
  input wire [21:0] dmAddr, // byte address
  input wire [7:0] dmWdata, // store byte
  output reg [7:0] dmRdata, // load byte
  output reg dmAck, // data done
  input wire pmReq, // code request
  input wire [21:0] pmAddr, // code address
  output reg [15:0] pmRdata, // code word
  output reg pmAck, // code done
  output reg [21:0] lastAddr, // address of last data access
  output reg lastWe, // direction of last data access
  output reg [7:0] lastData, // store byte of last data access
  output reg [21:0] pmLast // address of last code read
);
  reg [3:0] dmCnt; // data wait counter
  reg [3:0] pmCnt; // code wait counter
  initial begin
    dmAck = 1'b0;
    pmAck = 1'b0;
    dmRdata = 8'h00;
    pmRdata = 16'h0000;
    dmCnt = 4'h0;
    pmCnt = 4'h0;
  end
  // answer after lag cycles; read data toggles outside the answer so stale values never match
  always @(posedge ref_clk) begin
    dmAck <= 1'b0;
    pmAck <= 1'b0;
    dmRdata <= ~dmRdata;
    pmRdata <= ~pmRdata;
    if (dmReq && !dmAck) begin
      if (dmCnt == lag) begin
        dmAck <= 1'b1;
        dmRdata <= dmAddr[7:0] ^ 8'hA5;
        lastAddr <= dmAddr;
        lastWe <= dmWe;
        lastData <= dmWdata;
        dmCnt <= 4'h0;
      end else dmCnt <= dmCnt + 4'h1;
    end
    if (pmReq && !pmAck) begin
      if (pmCnt == lag) begin
        pmAck <= 1'b1;
        pmRdata <= pmAddr[15:0] ^ 16'h5A5A;
        pmLast <= pmAddr;
        pmCnt <= 4'h0;
      end else pmCnt <= pmCnt + 4'h1;
    end
  end
endmodule // mem_partner

//--- verification/core_load_instruction_decode_bench.sv
// self-checking bench for the load and move decoder
`timescale 1ns/1ps
module core_load_instruction_decode_bench;
  reg ref_clk; // 40 MHz core clock
  reg arst_n; // async reset, active low
  reg instrValid; // word offered
  reg [15:0] instrWord; // offered word
  reg [21:0] instrAddr; // first word address
  reg [3:0] dbgSel; // observed register
  reg [3:0] lag; // memory answer delay
  wire instrReady, dmReq, dmWe, dmAck, pmReq, pmAck, zeroFlagReg6, zeroFlagReg7, otherOp; // decoder status
  wire [21:0] dmAddr, pmAddr, lastAddr, pmLast; // addresses
  wire [7:0] dmWdata, dmRdata, lastData; // byte lanes
  wire [15:0] pmRdata, dbgGpr; // word lanes
  wire [5:0] dbgExt; // observed extension
  wire lastWe; // last data direction
  integer mismatches; // failed compares
  integer checked; // compares made
  core_load_instruction_decode dut (.ref_clk(ref_clk), .arst_n(arst_n), .instrValid(instrValid),
    .instrWord(instrWord), .instrAddr(instrAddr), .instrReady(instrReady), .dmReq(dmReq), .dmWe(dmWe),
    .dmAddr(dmAddr), .dmWdata(dmWdata), .dmRdata(dmRdata), .dmAck(dmAck), .pmReq(pmReq), .pmAddr(pmAddr),
    .pmRdata(pmRdata), .pmAck(pmAck), .zeroFlagReg6(zeroFlagReg6), .zeroFlagReg7(zeroFlagReg7),
    .otherOp(otherOp), .dbgSel(dbgSel), .dbgGpr(dbgGpr), .dbgExt(dbgExt));
  mem_partner mem (.ref_clk(ref_clk), .lag(lag), .dmReq(dmReq), .dmWe(dmWe), .dmAddr(dmAddr),
    .dmWdata(dmWdata), .dmRdata(dmRdata), .dmAck(dmAck), .pmReq(pmReq), .pmAddr(pmAddr), .pmRdata(pmRdata),
    .pmAck(pmAck), .lastAddr(lastAddr), .lastWe(lastWe), .lastData(lastData), .pmLast(pmLast));
  // free-running clock, 25 ns period
  always #12.5 ref_clk = ~ref_clk;
  task tally_and_finish;
    begin
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
    end
  endtask
  // four-state compare, so an unknown never matches
  task chk(input [21:0] got, input [21:0] exp);
    begin
      checked = checked + 1;
      if (got !== exp) begin
        mismatches = mismatches + 1;
        $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  // bounded wait for the decoder to accept words again
  task idle;
    integer n;
    begin
      n = 0;
      @(negedge ref_clk);
      while (instrReady !== 1'b1 && n < 60) begin
        @(negedge ref_clk);
        n = n + 1;
      end
      if (n >= 60) begin
        mismatches = mismatches + 1;
        $display("Error at %0t: decoder stuck busy", $time);
        tally_and_finish;
      end
    end
  endtask
  // offer one word for exactly one taking edge
  task put(input [15:0] w);
    begin
      idle;
      instrValid = 1'b1;
      instrWord = w;
      @(negedge ref_clk);
      instrValid = 1'b0;
    end
  endtask
  task put2(input [15:0] w1, input [15:0] w2);
    begin
      put(w1);
      put(w2);
    end
  endtask
  // register observation is one edge late, so allow two edges
  task rd(input [3:0] s, input [15:0] g);
    begin
      idle;
      dbgSel = s;
      repeat (2) @(negedge ref_clk);
      chk({6'h00, dbgGpr}, {6'h00, g});
    end
  endtask
  task rdx(input [3:0] s, input [5:0] e);
    begin
      idle;
      dbgSel = s;
      repeat (2) @(negedge ref_clk);
      chk({16'h0000, dbgExt}, {16'h0000, e});
    end
  endtask
  task mem_chk(input [21:0] a, input we, input [7:0] d);
    begin
      idle;
      chk(lastAddr, a);
      chk({21'h0, lastWe}, {21'h0, we});
      if (we) chk({14'h0, lastData}, {14'h0, d});
    end
  endtask
  task t_imm;
    begin
      chk({20'h0, zeroFlagReg7, zeroFlagReg6}, 22'h0);
      put2(16'h8DF6, 16'hFF00);
      rd(4'h6, 16'hFF00);
      put(16'h1600);
      rd(4'h6, 16'h0000);
      chk({20'h0, zeroFlagReg7, zeroFlagReg6}, 22'h1);
      put2(16'h8DF7, 16'h0000);
      chk({20'h0, zeroFlagReg7, zeroFlagReg6}, 22'h3);
      put(16'h1780);
      rd(4'h7, 16'h0080);
      chk({20'h0, zeroFlagReg7, zeroFlagReg6}, 22'h1);
    end
  endtask
  // a word of another group pulses otherOp for one cycle and leaves registers alone
  task t_other;
    begin
      put(16'hE780);
      chk({21'h0, otherOp}, 22'h1);
      @(negedge ref_clk);
      chk({21'h0, otherOp}, 22'h0);
      rd(4'h7, 16'h0080);
      chk({20'h0, zeroFlagReg7, zeroFlagReg6}, 22'h1);
    end
  endtask
  task t_ext;
    begin
      put2(16'hABAA, 16'hBEEF);
      rd(4'hB, 16'hBEEF);
      rdx(4'hB, 6'h2A);
      put(16'hAD1B);
      rd(4'hD, 16'hBEEF);
      rdx(4'hD, 6'h2A);
      put2(16'h8DF2, 16'hFFFF);
      put(16'hA219);
      rdx(4'h9, 6'h3F);
      put(16'hA411);
      rd(4'h4, 16'h003F);
    end
  endtask
  task t_byte;
    begin
      lag = 4'h3;
      put2(16'hAABF, 16'hFFFE);
      put(16'h6123);
      rd(4'h1, 16'h00A4);
      mem_chk(22'h000001, 1'b0, 8'h00);
      put(16'h7423);
      mem_chk(22'h000001, 1'b1, 8'h3F);
      lag = 4'h0;
      put2(16'hA332, 16'h0010);
      rd(4'h3, 16'h00AB);
      put2(16'hA33A, 16'h0020);
      mem_chk(22'h00001E, 1'b1, 8'hAB);
      put(16'h65A4);
      mem_chk(22'h00003D, 1'b0, 8'h00);
      rd(4'h5, 16'h0098);
      put(16'h75A4);
      mem_chk(22'h00003D, 1'b1, 8'h98);
      put2(16'hA880, 16'h1000);
      put(16'h9C7F);
      rd(4'h0, 16'h00DA);
      put(16'h9D80);
      mem_chk(22'h001080, 1'b1, 8'hDA);
    end
  endtask
  task t_code_pc;
    begin
      lag = 4'h2;
      put(16'hA603);
      rd(4'h6, 16'hE4B5);
      chk(pmLast, 22'h2ABEEF);
      instrAddr = 22'h15FFFE;
      put(16'h9EF4);
      rd(4'hC, 16'h0002);
      rdx(4'hC, 6'h16);
    end
  endtask
  task t_saved;
    integer s;
    begin
      for (s = 0; s < 16; s = s + 1) begin
        put2(16'h8DF0, 16'h5500 + s[15:0]);
        put(16'h9EB0 + s[15:0]);
      end
      for (s = 0; s < 16; s = s + 1) begin
        put(16'h1000);
        put(16'h9EA0 + s[15:0]);
        rd(4'h0, (s < 3 || s == 4 || s == 5 || s == 6 || s == 10) ? 16'h5500 + s[15:0] : 16'h0000);
      end
    end
  endtask
  // reset for three cycles, release on a falling edge, then run every scenario
  initial begin
    ref_clk = 1'b0;
    arst_n = 1'b0;
    instrValid = 1'b0;
    instrWord = 16'h0000;
    instrAddr = 22'h000000;
    dbgSel = 4'h0;
    lag = 4'h0;
    mismatches = 0;
    checked = 0;
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk);
    arst_n = 1'b1;
    t_imm;
    t_other;
    t_ext;
    t_byte;
    t_code_pc;
    t_saved;
    tally_and_finish;
  end
endmodule // core_load_instruction_decode_bench
